// *** include/doc_pkg.sv ***
package doc_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NUM_STAGES = 4;
  localparam int NUM_GROUPS = 8;
  localparam int NUM_PHASES = 3;
  localparam int MAG_W = 16;
  localparam int ANG_W = 13;
  localparam int CNT_W = 16;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_GLOBAL_CTRL = 8'h00;
  localparam logic [7:0] OFS_GLOBAL_STATUS = 8'h04;
  localparam logic [7:0] OFS_CNT_CLEAR = 8'h08;
  localparam logic [7:0] OFS_REF_ANGLE = 8'h0c;
  // stage s occupies 0x40 + 0x20*s; word index inside the stage window
  localparam logic [2:0] STAGE_WIN_FIRST = 3'h2;
  localparam logic [2:0] OFS_ST_CTRL = 3'h0;
  localparam logic [2:0] OFS_ST_PICKUP = 3'h1;
  localparam logic [2:0] OFS_ST_SECTOR = 3'h2;
  localparam logic [2:0] OFS_ST_DELAY = 3'h3;
  localparam logic [2:0] OFS_ST_STATUS = 3'h4;
  localparam logic [2:0] OFS_ST_CNT_ST = 3'h5;
  localparam logic [2:0] OFS_ST_CNT_BL = 3'h6;

  // field positions
  localparam int GC_FORCE_EN_BIT = 0;
  localparam int GC_LL_MODE_BIT = 1;
  localparam int GC_EDIT_GRP_LSB = 4;
  localparam int SC_FORCE_LSB = 0;
  localparam int SC_MAG_SEL_LSB = 2;
  localparam int SD_INVERSE_DELAY_CURVE_BIT = 16;
  localparam int SD_NONDIR_BIT = 17;

  // ----------------------------------------------------------------
  // reset values and limits (angles in 0.1 deg, current in 0.01 In)
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_PICKUP = 16'h0078;
  localparam logic [15:0] PICKUP_MIN = 16'h000a;
  localparam logic [15:0] PICKUP_MAX = 16'h0fa0;
  localparam logic [15:0] RST_WIDTH = 16'h0370;
  localparam logic [15:0] WIDTH_MIN = 16'h000a;
  localparam logic [15:0] WIDTH_MAX = 16'h06a4;
  localparam logic signed [12:0] RST_CENTER = 13'sh0000;
  localparam logic signed [12:0] ANG_HALF = 13'sh0708;
  localparam logic [15:0] RST_DELAY = 16'h000a;
  localparam logic [15:0] SECTOR_HYST = 16'h0014;
  localparam logic [15:0] VOLT_LOSS_LIMIT = 16'h0064;
  localparam logic [6:0] RATIO_FULL = 7'h64;
  localparam logic [6:0] RATIO_RESET = 7'h61;

  // ----------------------------------------------------------------
  // timing, counted in measurement updates
  // ----------------------------------------------------------------
  localparam int UPDATE_MS = 5;
  localparam int MEM_HOLD_MS = 500;
  localparam int MEM_LOOKBACK_MS = 100;
  localparam int MEM_HOLD_UPDATES = MEM_HOLD_MS / UPDATE_MS;
  localparam int LOOKBACK_UPDATES = MEM_LOOKBACK_MS / UPDATE_MS;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef logic signed [ANG_W-1:0] doc_angle_t;

  typedef enum logic [1:0] {
    MAG_RMS = 2'h0,
    MAG_TRMS = 2'h1,
    MAG_PP = 2'h2
  } doc_mag_e;

  typedef enum logic [1:0] {
    STAT_NORMAL = 2'h0,
    STAT_START = 2'h1,
    STAT_TRIP = 2'h2,
    STAT_BLOCKED = 2'h3
  } doc_status_e;

  typedef enum logic [3:0] {
    ST_NORMAL = 4'b0001,
    ST_START = 4'b0010,
    ST_TRIP = 4'b0100,
    ST_BLOCKED = 4'b1000
  } doc_stage_e;

  typedef enum logic [2:0] {
    REF_LIVE = 3'b001,
    REF_MEMORY = 3'b010,
    REF_ZERO = 3'b100
  } doc_ref_e;

  typedef struct packed {
    logic [NUM_PHASES-1:0][MAG_W-1:0] mag_rms;
    logic [NUM_PHASES-1:0][MAG_W-1:0] mag_trms;
    logic [NUM_PHASES-1:0][MAG_W-1:0] mag_pp;
    logic [MAG_W-1:0] u1_mag;
    doc_angle_t u1_ang;
    doc_angle_t i1_ang;
    doc_angle_t ll_healthy_ang;
    doc_angle_t impedance_ang;
    doc_angle_t faulty_i_ang;
    logic short_circuit;
    logic residual_avail;
  } doc_meas_s;

  typedef struct packed {
    logic start_on;
    logic start_off;
    logic trip_on;
    logic trip_off;
    logic block_on;
    logic block_off;
  } doc_event_s;

endpackage : doc_pkg

// *** design/doc_phase_cmp.sv ***
module doc_phase_cmp (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic update_in,
  input wire logic [doc_pkg::MAG_W-1:0] mag_in,
  input wire logic [doc_pkg::MAG_W-1:0] set_in,
  output logic pickup_out
);
  import doc_pkg::*;

  logic pickup_q;
  logic pickup_d;
  wire logic [22:0] mag_x100 = {7'h00, mag_in} * {16'h0000, RATIO_FULL};
  wire logic [22:0] set_x97 = {7'h00, set_in} * {16'h0000, RATIO_RESET};
  wire logic above = mag_in > set_in;
  wire logic below_reset = mag_x100 < set_x97;

  assign pickup_d = update_in ? (pickup_q ? !below_reset : above) : pickup_q;
  assign pickup_out = pickup_q;

  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      pickup_q <= 1'b0;
    end else begin
      pickup_q <= pickup_d;
    end
  end

endmodule : doc_phase_cmp

// *** design/doc_stage.sv ***
// Notes on behaviour
// - four independent stages share one measurement feed.
// - per stage, choose RMS, TRMS or peak-to-peak magnitude; RMS by default.
// - fault angle is current angle minus positive-sequence voltage angle.
// - below 1 V hold memory angle 0.5 s, then force reference to zero.
// - memory holds reference angle measured 100 ms before voltage loss.
// - global force enable applies per-stage forced status; Normal by default.
// - any phase above common pick-up setting raises pick-up.
// - pick-up releases below 97 percent of the setting.
// - pick-up setting in 0.01 In steps, default 1.20 In.
// - directional by default; non-directional needs magnitude only.
// - directional mode also needs fault angle inside the sector.
// - sector half-width 1.0 to 170.0 degrees, default 88.
// - sector centre -180.0 to 180.0 degrees, default 0, rotates sector.
// - line-to-line mode uses healthy line voltage, impedance angle in short circuits.
// - line-to-line single-phase fault: current reference from faulty phase.
// - sector exit needs 2 degrees beyond the boundary.
// - pick-up and sector settings follow active group; general settings do not.
// - blocking at pick-up gives Blocked; running Start timing is reset.
// - resettable Start, Trip, Blocked counters and stamped ON/OFF events.
// - definite or inverse delay from Start to Trip.
//
// The implementer's own choices: the APB register port and the register offsets.
module doc_stage (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic meas_valid_in,
  input wire doc_pkg::doc_meas_s meas_in,
  input wire logic [doc_pkg::NUM_STAGES-1:0] block_in,
  input wire logic [2:0] active_group_in,
  output logic [doc_pkg::NUM_STAGES-1:0] start_out,
  output logic [doc_pkg::NUM_STAGES-1:0] trip_out,
  output logic [doc_pkg::NUM_STAGES-1:0] blocked_out,
  output doc_pkg::doc_event_s [doc_pkg::NUM_STAGES-1:0] events_out,
  output logic [31:0] event_stamp_out
);
  import doc_pkg::*;

  // ----------------------------------------------------------------
  // settings storage
  // ----------------------------------------------------------------
  logic force_en_q;
  logic ll_mode_q;
  logic [2:0] edit_grp_q;
  logic [1:0] force_sel_q [NUM_STAGES];
  logic [1:0] mag_sel_q [NUM_STAGES];
  logic [15:0] pickup_q [NUM_STAGES][NUM_GROUPS];
  logic [15:0] width_q [NUM_STAGES][NUM_GROUPS];
  doc_angle_t center_q [NUM_STAGES][NUM_GROUPS];
  logic [15:0] delay_q [NUM_STAGES][NUM_GROUPS];
  logic inverse_delay_curve_q [NUM_STAGES][NUM_GROUPS];
  logic nondir_q [NUM_STAGES][NUM_GROUPS];
  logic [31:0] prdata_q;
  logic [31:0] stamp_q;

  function automatic logic [15:0] clamp_u(input logic [15:0] v, input logic [15:0] lo,
                                          input logic [15:0] hi);
    clamp_u = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clamp_u

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire logic [2:0] win = paddr_in[7:5];
  wire logic [2:0] word = paddr_in[4:2];
  wire logic in_stage_win = (win >= STAGE_WIN_FIRST) && (win < STAGE_WIN_FIRST + 3'h4);
  wire logic [1:0] sidx = 2'(win - STAGE_WIN_FIRST);
  wire logic glob_hit = (win == 3'h0) && (paddr_in[4] == 1'b0);
  wire logic stage_hit = in_stage_win && (word <= OFS_ST_CNT_BL);
  wire logic addr_hit = (glob_hit || stage_hit) && (paddr_in[1:0] == 2'h0);
  wire logic access = psel_in && penable_in;
  wire logic wr_en = access && pwrite_in && addr_hit;
  wire logic st_wr = wr_en && stage_hit;
  wire logic [NUM_STAGES-1:0] cnt_clr =
    (wr_en && paddr_in == OFS_CNT_CLEAR) ? pwdata_in[NUM_STAGES-1:0] : '0;

  assign pready_out = 1'b1;
  assign pslverr_out = access && !addr_hit;
  assign prdata_out = prdata_q;
  assign event_stamp_out = stamp_q;

  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      force_en_q <= 1'b0;
      ll_mode_q <= 1'b0;
      edit_grp_q <= 3'h0;
      for (int s = 0; s < NUM_STAGES; s++) begin
        force_sel_q[s] <= STAT_NORMAL;
        mag_sel_q[s] <= MAG_RMS;
        for (int g = 0; g < NUM_GROUPS; g++) begin
          pickup_q[s][g] <= RST_PICKUP;
          width_q[s][g] <= RST_WIDTH;
          center_q[s][g] <= RST_CENTER;
          delay_q[s][g] <= RST_DELAY;
          inverse_delay_curve_q[s][g] <= 1'b0;
          nondir_q[s][g] <= 1'b0;
        end
      end
    end else if (wr_en) begin
      if (paddr_in == OFS_GLOBAL_CTRL) begin
        force_en_q <= pwdata_in[GC_FORCE_EN_BIT];
        ll_mode_q <= pwdata_in[GC_LL_MODE_BIT];
        edit_grp_q <= pwdata_in[GC_EDIT_GRP_LSB +: 3];
      end
      if (st_wr && word == OFS_ST_CTRL) begin
        force_sel_q[sidx] <= pwdata_in[SC_FORCE_LSB +: 2];
        mag_sel_q[sidx] <= (pwdata_in[SC_MAG_SEL_LSB +: 2] == 2'h3) ? MAG_RMS
                                                                      : pwdata_in[SC_MAG_SEL_LSB +: 2];
      end
      if (st_wr && word == OFS_ST_PICKUP) begin
        pickup_q[sidx][edit_grp_q] <= clamp_u(pwdata_in[15:0], PICKUP_MIN, PICKUP_MAX);
      end
      if (st_wr && word == OFS_ST_SECTOR) begin
        width_q[sidx][edit_grp_q] <= clamp_u(pwdata_in[15:0], WIDTH_MIN, WIDTH_MAX);
        center_q[sidx][edit_grp_q] <=
          ($signed(pwdata_in[31:16]) > 16'(ANG_HALF)) ? ANG_HALF :
          ($signed(pwdata_in[31:16]) < -16'(ANG_HALF)) ? -ANG_HALF :
          doc_angle_t'(pwdata_in[28:16]);
      end
      if (st_wr && word == OFS_ST_DELAY) begin
        delay_q[sidx][edit_grp_q] <= pwdata_in[15:0];
        inverse_delay_curve_q[sidx][edit_grp_q] <= pwdata_in[SD_INVERSE_DELAY_CURVE_BIT];
        nondir_q[sidx][edit_grp_q] <= pwdata_in[SD_NONDIR_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // reference angle and angle memory
  // ----------------------------------------------------------------
  doc_ref_e ref_q;
  doc_ref_e ref_d;
  doc_angle_t hist_q [LOOKBACK_UPDATES];
  doc_angle_t mem_ang_q;
  logic [7:0] hold_cnt_q;

  wire logic upd = meas_valid_in;
  wire logic volt_low = meas_in.u1_mag < VOLT_LOSS_LIMIT;
  wire logic ll_single = ll_mode_q && !meas_in.residual_avail && !meas_in.short_circuit;
  wire doc_angle_t cur_ang = ll_single ? meas_in.faulty_i_ang : meas_in.i1_ang;
  wire doc_angle_t live_ref = !ll_mode_q ? meas_in.u1_ang :
                              (meas_in.short_circuit ? meas_in.impedance_ang
                                                     : meas_in.ll_healthy_ang);
  wire doc_angle_t ref_ang = (ref_q == REF_LIVE) ? live_ref :
                             (ref_q == REF_MEMORY) ? mem_ang_q : '0;
  wire logic hold_done = hold_cnt_q == 8'(MEM_HOLD_UPDATES - 1);

  always_comb begin
    ref_d = ref_q;
    unique case (ref_q)
      REF_LIVE: begin
        if (upd && volt_low) begin
          ref_d = REF_MEMORY;
        end
      end
      REF_MEMORY: begin
        if (upd && !volt_low) begin
          ref_d = REF_LIVE;
        end else if (upd && hold_done) begin
          ref_d = REF_ZERO;
        end
      end
      REF_ZERO: begin
        if (upd && !volt_low) begin
          ref_d = REF_LIVE;
        end
      end
      default: ref_d = REF_LIVE;
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      ref_q <= REF_LIVE;
      mem_ang_q <= '0;
      hold_cnt_q <= 8'h00;
      stamp_q <= 32'h0000_0000;
      for (int i = 0; i < LOOKBACK_UPDATES; i++) begin
        hist_q[i] <= '0;
      end
    end else begin
      ref_q <= ref_d;
      stamp_q <= stamp_q + 32'h0000_0001;
      if (upd && ref_q == REF_LIVE) begin
        hist_q[0] <= live_ref;
        for (int i = 1; i < LOOKBACK_UPDATES; i++) begin
          hist_q[i] <= hist_q[i-1];
        end
      end
      if (ref_q == REF_LIVE && ref_d == REF_MEMORY) begin
        mem_ang_q <= hist_q[LOOKBACK_UPDATES-1];
        hold_cnt_q <= 8'h00;
      end else if (upd && ref_q == REF_MEMORY && !hold_done) begin
        hold_cnt_q <= hold_cnt_q + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // per-stage evaluation
  // ----------------------------------------------------------------
  logic [1:0] stat_w [NUM_STAGES];
  logic pick_w [NUM_STAGES];
  logic insec_w [NUM_STAGES];
  doc_angle_t fang_w [NUM_STAGES];
  logic [CNT_W-1:0] cnt_start_w [NUM_STAGES];
  logic [CNT_W-1:0] cnt_trip_w [NUM_STAGES];
  logic [CNT_W-1:0] cnt_block_w [NUM_STAGES];

  for (genvar s = 0; s < NUM_STAGES; s++) begin : g_stage
    logic [NUM_PHASES-1:0] ph_pick;
    logic [NUM_PHASES-1:0][MAG_W-1:0] mags;
    logic [15:0] pickup;
    logic [15:0] width;
    doc_angle_t center;
    logic [15:0] delay;
    logic inverse_delay_curve;
    logic nondir;
    logic [14:0] raw;
    logic [14:0] wrap1;
    logic [14:0] wrap2;
    logic [14:0] mag_abs;
    logic [15:0] max_ab;
    logic [15:0] max_mag;
    logic [31:0] acc_q;
    logic [31:0] acc_lim;
    logic insec_q;
    logic qual;
    logic delay_done;
    doc_stage_e st_q;
    doc_stage_e st_d;
    logic [1:0] stat_q;
    logic [1:0] stat_now;
    doc_event_s ev_q;
    logic [CNT_W-1:0] c_start_q;
    logic [CNT_W-1:0] c_trip_q;
    logic [CNT_W-1:0] c_block_q;

    assign pickup = pickup_q[s][active_group_in];
    assign width = width_q[s][active_group_in];
    assign center = center_q[s][active_group_in];
    assign delay = delay_q[s][active_group_in];
    assign inverse_delay_curve = inverse_delay_curve_q[s][active_group_in];
    assign nondir = nondir_q[s][active_group_in];
    assign mags = (mag_sel_q[s] == MAG_TRMS) ? meas_in.mag_trms :
                  (mag_sel_q[s] == MAG_PP) ? meas_in.mag_pp : meas_in.mag_rms;

    for (genvar p = 0; p < NUM_PHASES; p++) begin : g_phase
      doc_phase_cmp u_cmp (
        .ref_clk_in(ref_clk_in),
        .rstn_in(rstn_in),
        .update_in(upd),
        .mag_in(mags[p]),
        .set_in(pickup),
        .pickup_out(ph_pick[p])
      );
    end

    // fault angle relative to the rotated sector, wrapped to +/-180 deg
    assign raw = 15'(cur_ang) - 15'(ref_ang) - 15'(center);
    assign wrap1 = ($signed(raw) > 15'(ANG_HALF)) ? raw - 15'sd3600 :
                   ($signed(raw) < -15'(ANG_HALF)) ? raw + 15'sd3600 : raw;
    assign wrap2 = ($signed(wrap1) > 15'(ANG_HALF)) ? wrap1 - 15'sd3600 :
                   ($signed(wrap1) < -15'(ANG_HALF)) ? wrap1 + 15'sd3600 : wrap1;
    assign mag_abs = wrap2[14] ? 15'(-$signed(wrap2)) : wrap2;

    assign max_ab = (mags[0] > mags[1]) ? mags[0] : mags[1];
    assign max_mag = (max_ab > mags[2]) ? max_ab : mags[2];
    assign acc_lim = inverse_delay_curve ? {16'h0000, delay} * {16'h0000, pickup} : {16'h0000, delay};
    assign delay_done = acc_q >= acc_lim;
    assign qual = (|ph_pick) && (nondir || insec_q);

    always_comb begin
      st_d = st_q;
      unique case (st_q)
        ST_NORMAL: begin
          if (qual && block_in[s]) begin
            st_d = ST_BLOCKED;
          end else if (qual) begin
            st_d = ST_START;
          end
        end
        ST_START: begin
          if (!qual) begin
            st_d = ST_NORMAL;
          end else if (block_in[s]) begin
            st_d = ST_BLOCKED;
          end else if (delay_done) begin
            st_d = ST_TRIP;
          end
        end
        ST_TRIP: begin
          if (!qual) begin
            st_d = ST_NORMAL;
          end else if (block_in[s]) begin
            st_d = ST_BLOCKED;
          end
        end
        ST_BLOCKED: begin
          if (!qual || !block_in[s]) begin
            st_d = ST_NORMAL;
          end
        end
        default: st_d = ST_NORMAL;
      endcase
    end

    assign stat_now = force_en_q ? force_sel_q[s] :
                      (st_q == ST_START) ? STAT_START :
                      (st_q == ST_TRIP) ? STAT_TRIP :
                      (st_q == ST_BLOCKED) ? STAT_BLOCKED : STAT_NORMAL;

    always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
        st_q <= ST_NORMAL;
        insec_q <= 1'b0;
        acc_q <= 32'h0000_0000;
      end else if (upd) begin
        st_q <= st_d;
        insec_q <= insec_q ? (16'(mag_abs) <= width + SECTOR_HYST)
                           : (16'(mag_abs) <= width);
        acc_q <= (st_d == ST_START) ? acc_q + (inverse_delay_curve ? {16'h0000, max_mag} : 32'h0000_0001)
                                    : 32'h0000_0000;
      end
    end

    always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
        stat_q <= STAT_NORMAL;
        ev_q <= '0;
        c_start_q <= '0;
        c_trip_q <= '0;
        c_block_q <= '0;
      end else begin
        stat_q <= stat_now;
        ev_q.start_on <= stat_now == STAT_START && stat_q != STAT_START;
        ev_q.start_off <= stat_now != STAT_START && stat_q == STAT_START;
        ev_q.trip_on <= stat_now == STAT_TRIP && stat_q != STAT_TRIP;
        ev_q.trip_off <= stat_now != STAT_TRIP && stat_q == STAT_TRIP;
        ev_q.block_on <= stat_now == STAT_BLOCKED && stat_q != STAT_BLOCKED;
        ev_q.block_off <= stat_now != STAT_BLOCKED && stat_q == STAT_BLOCKED;
        // a count arriving with the clear is kept as one
        if (cnt_clr[s]) begin
          c_start_q <= CNT_W'(ev_q.start_on);
          c_trip_q <= CNT_W'(ev_q.trip_on);
          c_block_q <= CNT_W'(ev_q.block_on);
        end else begin
          c_start_q <= c_start_q + CNT_W'(ev_q.start_on);
          c_trip_q <= c_trip_q + CNT_W'(ev_q.trip_on);
          c_block_q <= c_block_q + CNT_W'(ev_q.block_on);
        end
      end
    end

    assign start_out[s] = stat_q == STAT_START;
    assign trip_out[s] = stat_q == STAT_TRIP;
    assign blocked_out[s] = stat_q == STAT_BLOCKED;
    assign events_out[s] = ev_q;
    assign stat_w[s] = stat_q;
    assign pick_w[s] = |ph_pick;
    assign insec_w[s] = insec_q;
    assign fang_w[s] = doc_angle_t'(wrap2);
    assign cnt_start_w[s] = c_start_q;
    assign cnt_trip_w[s] = c_trip_q;
    assign cnt_block_w[s] = c_block_q;
  end

  // ----------------------------------------------------------------
  // read mux, captured in the setup phase
  // ----------------------------------------------------------------
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (glob_hit) begin
      unique case (paddr_in[3:2])
        2'h0: rd_mux = {25'h0, edit_grp_q, 2'h0, ll_mode_q, force_en_q};
        2'h1: rd_mux = {25'h0, active_group_in, 1'b0, ref_q};
        2'h2: rd_mux = 32'h0000_0000;
        2'h3: rd_mux = {{19{ref_ang[ANG_W-1]}}, ref_ang};
      endcase
    end else if (stage_hit) begin
      unique case (word)
        OFS_ST_CTRL: rd_mux = {28'h0, mag_sel_q[sidx], force_sel_q[sidx]};
        OFS_ST_PICKUP: rd_mux = {16'h0, pickup_q[sidx][edit_grp_q]};
        OFS_ST_SECTOR: rd_mux = {{3{center_q[sidx][edit_grp_q][ANG_W-1]}},
                                 center_q[sidx][edit_grp_q], width_q[sidx][edit_grp_q]};
        OFS_ST_DELAY: rd_mux = {14'h0, nondir_q[sidx][edit_grp_q],
                                inverse_delay_curve_q[sidx][edit_grp_q], delay_q[sidx][edit_grp_q]};
        OFS_ST_STATUS: rd_mux = {{3{fang_w[sidx][ANG_W-1]}}, fang_w[sidx], 12'h0,
                                 pick_w[sidx], insec_w[sidx], stat_w[sidx]};
        OFS_ST_CNT_ST: rd_mux = {cnt_trip_w[sidx], cnt_start_w[sidx]};
        OFS_ST_CNT_BL: rd_mux = {16'h0, cnt_block_w[sidx]};
        default: rd_mux = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel_in && !penable_in) begin
      prdata_q <= rd_mux;
    end
  end

endmodule : doc_stage

// *** verif/doc_assertions.sv ***
module doc_assertions (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic meas_valid_in,
  input wire logic [3:0] block_in,
  input wire logic [3:0] start_out,
  input wire logic [3:0] trip_out,
  input wire logic [3:0] blocked_out,
  input wire doc_pkg::doc_event_s [3:0] events_out
);
  timeunit 1ns;
  timeprecision 1ns;
  import doc_pkg::*;
  // --------------------
  // stage status checks
  // --------------------
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rstn_in);
  sequence s_start_up;
    $rose(start_out[0]);
  endsequence
  sequence s_recent_upd;
    $past(meas_valid_in) || $past(meas_valid_in, 2);
  endsequence
  a_block_alone: assert property (!(|(blocked_out & (start_out | trip_out))))
    else $error("blocked with start or trip");
  a_block_cause: assert property ($rose(blocked_out[0]) |-> $past(block_in[0], 2))
    else $error("blocked without block input");
  a_start_event: assert property (s_start_up |-> events_out[0].start_on)
    else $error("start on event missing");
  a_trip_off_event: assert property ($fell(trip_out[0]) |-> events_out[0].trip_off)
    else $error("trip off event missing");
  a_block_event: assert property ($rose(blocked_out[0]) |-> events_out[0].block_on)
    else $error("block on event missing");
  a_event_one_cycle: assert property (events_out[0].start_on |=> !events_out[0].start_on)
    else $error("event longer than one cycle");
  a_trip_via_start: assert property ($rose(trip_out[0]) |-> $past(start_out[0]))
    else $error("trip without start");
  a_start_on_update: assert property (s_start_up |-> s_recent_upd)
    else $error("start away from update");
endmodule : doc_assertions

bind doc_stage doc_assertions i_doc_assertions (.*);

// *** verif/doc_meas_model.sv ***
module doc_meas_model #(
  parameter int PERIOD = 8
) (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic [15:0] cur_in,
  input wire doc_pkg::doc_angle_t i_ang_in,
  input wire doc_pkg::doc_angle_t u_ang_in,
  input wire logic [15:0] u_mag_in,
  output logic meas_valid_out,
  output doc_pkg::doc_meas_s meas_out
);
  timeunit 1ns;
  timeprecision 1ns;
  import doc_pkg::*;
  logic [7:0] tick_q;
  // --------------------
  // update strobe and values
  // --------------------
  always @(posedge ref_clk_in) begin
    tick_q <= (!rstn_in || tick_q == PERIOD - 1) ? 8'h00 : tick_q + 8'h01;
  end
  assign meas_valid_out = rstn_in && tick_q == 8'h00;
  always_comb begin
    meas_out = '0;
    meas_out.mag_rms[0] = cur_in;
    meas_out.mag_trms[0] = cur_in >> 1;
    meas_out.mag_pp[0] = cur_in << 1;
    meas_out.u1_mag = u_mag_in;
    meas_out.u1_ang = u_ang_in;
    meas_out.i1_ang = i_ang_in;
  end
endmodule : doc_meas_model

// *** verif/doc_stage_test.sv ***
module doc_stage_test;
  timeunit 1ns;
  timeprecision 1ns;
  import doc_pkg::*;
  logic clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0, mv, prdy, perr, e;
  logic [7:0] pa = '0;
  logic [31:0] pwd = '0, prd, d, stamp;
  logic [15:0] cur = '0, umag = 16'h2710;
  doc_angle_t iang = '0, uang = '0;
  logic [3:0] blk = '0, st, tr, bl;
  doc_meas_s meas;
  int bad_count = 0, cmp_count = 0, cyc = 0;
  logic [15:0] cv [9] = '{121, 117, 116, 119, 200, 200, 200, 200, 200};
  int av [9] = '{0, 0, 0, 0, 901, 890, 880, 899, 901};
  logic ev [9] = '{1, 1, 0, 0, 0, 0, 1, 1, 0};
  always #25 clk = ~clk;
  doc_meas_model i_doc_meas_model (.ref_clk_in(clk), .rstn_in(rstn), .cur_in(cur),
    .i_ang_in(iang), .u_ang_in(uang), .u_mag_in(umag), .meas_valid_out(mv), .meas_out(meas));
  doc_stage i_doc_stage (.ref_clk_in(clk), .rstn_in(rstn), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd), .prdata_out(prd), .pready_out(prdy),
    .pslverr_out(perr), .meas_valid_in(mv), .meas_in(meas), .block_in(blk),
    .active_group_in(3'h0), .start_out(st), .trip_out(tr), .blocked_out(bl),
    .events_out(), .event_stamp_out(stamp));
  // --------------------
  // tasks
  // --------------------
  task automatic chk(string n, logic [31:0] s, logic [31:0] x);
    cmp_count++;
    if (s !== x) begin
      bad_count++;
      $display("BAD %s exp %h got %h", n, x, s);
    end
  endtask : chk
  task automatic apb(logic w, logic [7:0] a, logic [31:0] v);
    psel <= 1;
    pwr <= w;
    pa <= a;
    pwd <= v;
    @(posedge clk);
    pen <= 1;
    do @(posedge clk); while (prdy !== 1'b1);
    d = prd;
    e = perr;
    psel <= 0;
    pen <= 0;
    @(posedge clk);
  endtask : apb
  task automatic upd(int n);
    repeat (n) @(posedge clk iff mv);
    repeat (2) @(posedge clk);
  endtask : upd
  task automatic end_sim();
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      bad_count++;
      end_sim();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1;
    apb(0, 8'h44, 0); chk("pickup", d, 32'h78);
    apb(0, 8'h48, 0); chk("sector", d, 32'h370);
    apb(0, 8'h20, 0); chk("unmapped", 32'(e), 32'h1);
    for (int i = 0; i < 9; i++) begin
      cur <= cv[i];
      iang <= doc_angle_t'(av[i]);
      upd(3); chk("start", 32'(st[0]), 32'(ev[i]));
    end
    iang <= '0;
    for (int k = 0; k < 3; k++) begin
      apb(1, 8'h40, 32'(k) << 2);
      upd(3); chk("magsel", 32'(st[0]), 32'(k != 1));
    end
    $display("test pickup done");
    iang <= 13'sd1800;
    apb(1, 8'h4c, 32'h2000a);
    upd(3); chk("nondir", 32'(st[0]), 32'h1);
    upd(12); chk("trip", 32'(tr[0]), 32'h1);
    cur <= '0;
    upd(3); chk("trip off", 32'(tr[0]), 32'h0);
    blk <= 4'h1;
    cur <= 16'd200;
    upd(3); chk("blocked", {st[0], bl[0]}, 32'h1);
    cur <= '0;
    blk <= '0;
    upd(3); apb(0, 8'h58, 0); chk("blk cnt", d, 32'h1);
    apb(1, 8'h08, 32'h1); apb(0, 8'h58, 0); chk("cnt clr", d, 32'h0);
    apb(1, 8'h00, 32'h1);
    for (int k = 0; k < 4; k++) begin
      apb(1, 8'ha0, 32'(k));
      upd(1); chk("force", {bl[3], tr[3], st[3]}, (k == 0) ? 0 : 1 << (k - 1));
    end
    apb(1, 8'ha0, 0);
    apb(1, 8'h00, 0);
    $display("test status done");
    uang <= 13'sd300;
    upd(25);
    uang <= 13'sd100;
    upd(5);
    umag <= 16'd50;
    upd(3); apb(0, 8'h04, 0); chk("mem", d & 7, 32'h2);
    apb(0, 8'h0c, 0); chk("mem ang", d, 32'd300);
    upd(100); apb(0, 8'h04, 0); chk("zero", d & 7, 32'h4);
    apb(0, 8'h0c, 0); chk("zero ang", d, 32'h0);
    umag <= 16'h2710;
    upd(3); apb(0, 8'h04, 0); chk("live", d & 7, 32'h1);
    apb(0, 8'h0c, 0); chk("live ang", d, 32'd100);
    apb(1, 8'h00, 32'h2); apb(0, 8'h0c, 0); chk("ll ang", d, 32'h0);
    $display("test reference done");
    @(negedge clk) chk("stamp", stamp, 32'(cyc - 20));
    end_sim();
  end
endmodule : doc_stage_test
